// *** common/mpfs_consts.svh ***
// Function
// RQ1: each pin function register keeps a 5-bit code in bits 4:0 and three spare bits above, all read/write; all but the sixth reset to zero.
// RQ2: the bit clock pin register sits at index 0x3a, resets to zero, and code 00000 keeps the pin as serial bit clock.
// RQ3: code 00000, the reset choice, keeps the frame clock pin as the serial left/right frame clock.
// RQ4: code 00000, the reset choice, lets the first mic pin carry interleaved mic channels 0 and 1.
// RQ5: code 00000, the reset choice, lets the second mic pin carry interleaved mic channels 2 and 3.
// RQ6: codes 00001 to 00100 mute ADC 0 to 3 alone, 00101 mutes ADCs 0 and 1, 00110 ADCs 2 and 3, 00111 all four.
// RQ7: code 01000 mutes DAC0, 01001 mutes DAC1 and 01010 mutes both DACs.
// RQ8: code 01011 makes the pin the A/B bank switch and 01110 the compression enable.
// RQ9: code 01111 makes the pin a control input that bypasses the audio processing core.
// RQ10: code 10000 makes the pin the volume-up button and 10001 the volume-down button.
// RQ11: software never writes the spare codes 01100 and 01101 into any pin function register.
// RQ12: the second mic pin register sits at index 0x3d and resets to zero, selecting mic input.
// RQ13: the sixth pin register sits at index 0x3e and resets to 0x11, selecting volume-down; the code decodes no sixth pin, so fn_r[4] drives no control.
// RQ14: a pin used as a control input is synchronised first, and a pin in its primary role drives no control.
// RQ15: codes above 10001 select nothing and leave the pin an inactive input.
`ifndef MPFS_CONSTS_SVH
`define MPFS_CONSTS_SVH

// register indices; byte address is four times the index
`define MPFS_IDX_BCLK  8'h3a
`define MPFS_IDX_FCLK  8'h3b
`define MPFS_IDX_MICA  8'h3c
`define MPFS_IDX_MICB  8'h3d
`define MPFS_IDX_SIXTH 8'h3e
`define MPFS_NREG      5
`define MPFS_SIXTH_POS 4

// reset values
`define MPFS_RST_PIN   8'h00
`define MPFS_RST_SIXTH 8'h11

// field layout
`define MPFS_CODE_MSB  4
`define MPFS_REG_MSB   7
`define MPFS_ADR_W     10

`endif

// *** common/mpfs_pkg.sv ***
package mpfs_pkg;

  // pin function codes
  typedef enum logic [4:0] {
    code_primary    = 5'b00000,
    code_mute_adc0  = 5'b00001,
    code_mute_adc1  = 5'b00010,
    code_mute_adc2  = 5'b00011,
    code_mute_adc3  = 5'b00100,
    code_mute_adc01 = 5'b00101,
    code_mute_adc23 = 5'b00110,
    code_mute_adcs  = 5'b00111,
    code_mute_dac0  = 5'b01000,
    code_mute_dac1  = 5'b01001,
    code_mute_dacs  = 5'b01010,
    code_bank_sw    = 5'b01011,
    code_spare_a    = 5'b01100,
    code_spare_b    = 5'b01101,
    code_compress   = 5'b01110,
    code_bypass     = 5'b01111,
    code_vol_up     = 5'b10000,
    code_vol_down   = 5'b10001
  } mpfs_code_t;

  // control requests one pin can raise
  typedef struct packed {
    logic [3:0] mute_adc;
    logic [1:0] mute_dac;
    logic       bank_sw;
    logic       compress;
    logic       bypass;
    logic       vol_up;
    logic       vol_down;
  } mpfs_ctl_t;

endpackage

// *** hw/mpfs_pin_decode.sv ***
`timescale 1ns/100ps
module mpfs_pin_decode
  import mpfs_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       pin,
  input  wire logic [4:0] code,
  output logic            pin_sync,
  output mpfs_ctl_t       ctl
);

  logic meta_r;
  logic sync_r;

  // two-stage synchroniser; meta_r feeds sync_r only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end else begin
      meta_r <= pin;
      sync_r <= meta_r; // [RQ14]
    end
  end

  assign pin_sync = sync_r;

  // code to control request, only the synced level is used
  always_comb begin
    ctl = '0;
    if (sync_r) begin
      case (code)
        code_mute_adc0:  ctl.mute_adc = 4'h1; // [RQ6]
        code_mute_adc1:  ctl.mute_adc = 4'h2;
        code_mute_adc2:  ctl.mute_adc = 4'h4;
        code_mute_adc3:  ctl.mute_adc = 4'h8;
        code_mute_adc01: ctl.mute_adc = 4'h3;
        code_mute_adc23: ctl.mute_adc = 4'hc;
        code_mute_adcs:  ctl.mute_adc = 4'hf;
        code_mute_dac0:  ctl.mute_dac = 2'h1; // [RQ7]
        code_mute_dac1:  ctl.mute_dac = 2'h2;
        code_mute_dacs:  ctl.mute_dac = 2'h3;
        code_bank_sw:    ctl.bank_sw  = 1'b1; // [RQ8]
        code_compress:   ctl.compress = 1'b1;
        code_bypass:     ctl.bypass   = 1'b1; // [RQ9]
        code_vol_up:     ctl.vol_up   = 1'b1; // [RQ10]
        code_vol_down:   ctl.vol_down = 1'b1;
        // primary role, spare and undefined codes raise nothing
        default:         ctl = '0; // [RQ14] [RQ15]
      endcase
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_primary_silent;
    code == code_primary |-> ctl == '0;
  endproperty
  a_primary_silent: assert property (p_primary_silent) // [RQ14]
    else $error("primary-role pin raised a control");

  property p_undefined_silent;
    code > code_vol_down |-> ctl == '0;
  endproperty
  a_undefined_silent: assert property (p_undefined_silent) // [RQ15]
    else $error("undefined code raised a control");

endmodule

// *** hw/mpfs_top.sv ***
`timescale 1ns/100ps
`include "mpfs_consts.svh"
module mpfs_top
  import mpfs_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  // classic wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [9:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // multipurpose pins, inputs only here
  input  wire logic        bit_clock_pin,
  input  wire logic        frame_clock_pin,
  input  wire logic        mic_pair_a_pin,
  input  wire logic        mic_pair_b_pin,
  // primary roles
  output logic             serial_bit_clock,
  output logic             serial_frame_clock,
  output logic             mic_pair_a_data,
  output logic             mic_pair_b_data,
  // control functions
  output logic      [3:0]  mute_adc,
  output logic      [1:0]  mute_dac,
  output logic             bank_switch,
  output logic             compress_en,
  output logic             dsp_bypass,
  output logic             vol_up_req,
  output logic             vol_down_req
);

  ////////////////////////////////////////////////////////////////////////////////
  // register bus

  logic [7:0]              fn_r [0:`MPFS_NREG-1];
  logic                    ack_r;
  logic [31:0]             dat_r;
  logic                    req;
  logic                    wr_en;
  logic [7:0]              word;
  logic [`MPFS_NREG-1:0]   hit;
  logic [7:0]              rd_byte;

  assign req   = wb_cyc_i & wb_stb_i;
  assign word  = wb_adr_i[`MPFS_ADR_W-1:2];
  // write lands on the edge where the master sees ack
  assign wr_en = req & wb_we_i & ack_r & wb_sel_i[0];

  // one-hot register select from word index
  always_comb begin
    hit     = '0;
    rd_byte = 8'h00;
    for (int i = 0; i < `MPFS_NREG; i++) begin
      if (word == `MPFS_IDX_BCLK + 8'(i)) begin
        hit[i]  = 1'b1;
        rd_byte = fn_r[i];
      end
    end
  end

  // ack one cycle after the request, dropped the next
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req & ~ack_r;
    end
  end

  // read data loaded with ack; unmapped words read zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dat_r <= 32'h0000_0000;
    end else if (req & ~ack_r) begin
      dat_r <= {24'h00_0000, rd_byte};
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

  // function registers, all eight bits kept as written
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < `MPFS_NREG; i++) begin
        fn_r[i] <= (i == `MPFS_SIXTH_POS) ? `MPFS_RST_SIXTH : `MPFS_RST_PIN; // [RQ1] [RQ13]
      end
    end else begin
      for (int i = 0; i < `MPFS_NREG; i++) begin
        if (wr_en && hit[i]) begin
          fn_r[i] <= wb_dat_i[`MPFS_REG_MSB:0]; // [RQ1] [RQ2] [RQ12]
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // per-pin decode

  logic [4:0] bit_clock_pin_code;
  logic [4:0] frame_clock_pin_code;
  logic [4:0] mic_pair_a_pin_code;
  logic [4:0] mic_pair_b_pin_code;

  assign bit_clock_pin_code   = fn_r[0][`MPFS_CODE_MSB:0];
  assign frame_clock_pin_code = fn_r[1][`MPFS_CODE_MSB:0];
  assign mic_pair_a_pin_code  = fn_r[2][`MPFS_CODE_MSB:0];
  assign mic_pair_b_pin_code  = fn_r[3][`MPFS_CODE_MSB:0];

  mpfs_ctl_t ctl_bclk;
  mpfs_ctl_t ctl_fclk;
  mpfs_ctl_t ctl_mica;
  mpfs_ctl_t ctl_micb;
  mpfs_ctl_t ctl_all;
  logic      sync_mica;
  logic      sync_micb;

  mpfs_pin_decode u_dec_bclk (
    .clk      (clk),
    .rst_n    (rst_n),
    .pin      (bit_clock_pin),
    .code     (bit_clock_pin_code),
    .pin_sync (),
    .ctl      (ctl_bclk)
  );

  mpfs_pin_decode u_dec_fclk (
    .clk      (clk),
    .rst_n    (rst_n),
    .pin      (frame_clock_pin),
    .code     (frame_clock_pin_code),
    .pin_sync (),
    .ctl      (ctl_fclk)
  );

  mpfs_pin_decode u_dec_mica (
    .clk      (clk),
    .rst_n    (rst_n),
    .pin      (mic_pair_a_pin),
    .code     (mic_pair_a_pin_code),
    .pin_sync (sync_mica),
    .ctl      (ctl_mica)
  );

  mpfs_pin_decode u_dec_micb (
    .clk      (clk),
    .rst_n    (rst_n),
    .pin      (mic_pair_b_pin),
    .code     (mic_pair_b_pin_code),
    .pin_sync (sync_micb),
    .ctl      (ctl_micb)
  );

  // several pins may share a function; any active one wins
  assign ctl_all = ctl_bclk | ctl_fclk | ctl_mica | ctl_micb;

  ////////////////////////////////////////////////////////////////////////////////
  // outputs

  // registered controls: one cycle past the synchroniser
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mute_adc     <= 4'h0;
      mute_dac     <= 2'h0;
      bank_switch  <= 1'b0;
      compress_en  <= 1'b0;
      dsp_bypass   <= 1'b0;
      vol_up_req   <= 1'b0;
      vol_down_req <= 1'b0;
    end else begin
      mute_adc     <= ctl_all.mute_adc; // [RQ6]
      mute_dac     <= ctl_all.mute_dac; // [RQ7]
      bank_switch  <= ctl_all.bank_sw;  // [RQ8]
      compress_en  <= ctl_all.compress; // [RQ8]
      dsp_bypass   <= ctl_all.bypass;   // [RQ9]
      vol_up_req   <= ctl_all.vol_up;   // [RQ10]
      vol_down_req <= ctl_all.vol_down; // [RQ10]
    end
  end

  // clocks pass ungated-by-flop: resampling at 25 MHz would mangle them
  assign serial_bit_clock   = bit_clock_pin & (bit_clock_pin_code == code_primary);     // [RQ2]
  assign serial_frame_clock = frame_clock_pin & (frame_clock_pin_code == code_primary); // [RQ3]

  // mic streams are data: taken from the synchroniser, then a flop
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mic_pair_a_data <= 1'b0;
      mic_pair_b_data <= 1'b0;
    end else begin
      mic_pair_a_data <= sync_mica & (mic_pair_a_pin_code == code_primary); // [RQ4]
      mic_pair_b_data <= sync_micb & (mic_pair_b_pin_code == code_primary); // [RQ5]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // a pin held high under one code for three edges
  sequence s_bclk_held(logic [4:0] c);
    (bit_clock_pin_code == c && bit_clock_pin)[*3];
  endsequence

  sequence s_mica_held(logic [4:0] c);
    (mic_pair_a_pin_code == c && mic_pair_a_pin)[*3];
  endsequence

  sequence s_fclk_held(logic [4:0] c);
    (frame_clock_pin_code == c && frame_clock_pin)[*3];
  endsequence

  sequence s_micb_held(logic [4:0] c);
    (mic_pair_b_pin_code == c && mic_pair_b_pin)[*3];
  endsequence

  // all four pins low long enough to flush the synchronisers
  sequence s_pins_quiet;
    (!bit_clock_pin && !frame_clock_pin && !mic_pair_a_pin && !mic_pair_b_pin)[*3];
  endsequence

  sequence s_wr_to(logic [7:0] idx);
    wr_en && word == idx;
  endsequence

  property p_bus_ack;
    req && !ack_r |=> ack_r ##1 !ack_r;
  endproperty
  a_bus_ack: assert property (p_bus_ack) // [RQ1]
    else $error("ack not one cycle after request");

  property p_bclk_write;
    s_wr_to(`MPFS_IDX_BCLK) |=> fn_r[0] == $past(wb_dat_i[7:0]);
  endproperty
  a_bclk_write: assert property (p_bclk_write) // [RQ2]
    else $error("bit clock pin register did not take write");

  property p_micb_read;
    req && !ack_r && !wb_we_i && word == `MPFS_IDX_MICB
      |=> wb_ack_o && wb_dat_o == {24'h00_0000, $past(fn_r[3])};
  endproperty
  a_micb_read: assert property (p_micb_read) // [RQ12]
    else $error("second mic register read wrong");

  property p_sixth_read;
    req && !ack_r && !wb_we_i && word == `MPFS_IDX_SIXTH
      |=> wb_dat_o[31:8] == 24'h00_0000 && wb_dat_o[7:0] == $past(fn_r[4]);
  endproperty
  a_sixth_read: assert property (p_sixth_read) // [RQ13]
    else $error("sixth pin register read wrong");

  property p_bclk_primary;
    bit_clock_pin_code == code_primary |-> serial_bit_clock == bit_clock_pin;
  endproperty
  a_bclk_primary: assert property (p_bclk_primary) // [RQ2]
    else $error("bit clock not passed in primary role");

  property p_fclk_primary;
    frame_clock_pin_code != code_primary |-> !serial_frame_clock;
  endproperty
  a_fclk_primary: assert property (p_fclk_primary) // [RQ3]
    else $error("frame clock leaked while pin repurposed");

  property p_mica_stream;
    s_mica_held(code_primary) |=> mic_pair_a_data;
  endproperty
  a_mica_stream: assert property (p_mica_stream) // [RQ4]
    else $error("mic pair a stream lost");

  property p_micb_gate;
    (mic_pair_b_pin_code != code_primary)[*3] |=> !mic_pair_b_data;
  endproperty
  a_micb_gate: assert property (p_micb_gate) // [RQ5]
    else $error("mic pair b stream leaked while repurposed");

  property p_mute_adc0;
    s_bclk_held(code_mute_adc0) |=> mute_adc[0];
  endproperty
  a_mute_adc0: assert property (p_mute_adc0) // [RQ6]
    else $error("adc0 mute missing");

  property p_mute_adcs;
    s_mica_held(code_mute_adcs) |=> mute_adc == 4'hf;
  endproperty
  a_mute_adcs: assert property (p_mute_adcs) // [RQ6]
    else $error("all-adc mute missing");

  property p_mute_dacs;
    s_fclk_held(code_mute_dacs) |=> mute_dac == 2'h3;
  endproperty
  a_mute_dacs: assert property (p_mute_dacs) // [RQ7]
    else $error("both-dac mute missing");

  property p_bank;
    s_mica_held(code_bank_sw) |=> bank_switch;
  endproperty
  a_bank: assert property (p_bank) // [RQ8]
    else $error("bank switch missing");

  property p_bypass;
    s_bclk_held(code_bypass) |=> dsp_bypass;
  endproperty
  a_bypass: assert property (p_bypass) // [RQ9]
    else $error("dsp bypass missing");

  property p_vol_down;
    s_mica_held(code_vol_down) |=> vol_down_req;
  endproperty
  a_vol_down: assert property (p_vol_down) // [RQ10]
    else $error("volume down missing");

  property p_sync_delay;
    !ctl_all.vol_up |=> !vol_up_req;
  endproperty
  a_sync_delay: assert property (p_sync_delay) // [RQ14]
    else $error("volume up without synced cause");

  property p_mute_adc1;
    s_fclk_held(code_mute_adc1) |=> mute_adc[1];
  endproperty
  a_mute_adc1: assert property (p_mute_adc1) // [RQ6]
    else $error("adc1 mute missing");

  property p_mute_dac0;
    s_micb_held(code_mute_dac0) |=> mute_dac[0];
  endproperty
  a_mute_dac0: assert property (p_mute_dac0) // [RQ7]
    else $error("dac0 mute missing");

  property p_compress;
    s_micb_held(code_compress) |=> compress_en;
  endproperty
  a_compress: assert property (p_compress) // [RQ8]
    else $error("compression enable missing");

  property p_vol_up;
    s_micb_held(code_vol_up) |=> vol_up_req;
  endproperty
  a_vol_up: assert property (p_vol_up) // [RQ10]
    else $error("volume up missing");

  // spare bits must be kept along with the code
  property p_fclk_write;
    s_wr_to(`MPFS_IDX_FCLK) |=> fn_r[1] == $past(wb_dat_i[`MPFS_REG_MSB:0]);
  endproperty
  a_fclk_write: assert property (p_fclk_write) // [RQ1]
    else $error("frame clock pin register did not keep all bits");

  // a control can only come from a level that went through the synchroniser
  property p_pins_quiet;
    s_pins_quiet |=> mute_adc == 4'h0 && mute_dac == 2'h0 && !bank_switch && !compress_en
      && !dsp_bypass && !vol_up_req && !vol_down_req;
  endproperty
  a_pins_quiet: assert property (p_pins_quiet) // [RQ14]
    else $error("control raised with all pins quiet");

endmodule

// *** testbench/mpfs_pin_model.sv ***
`timescale 1ns/100ps
module mpfs_pin_model (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [3:0] press,
  output logic      [3:0] pins
);
  //////////////////////////////////////////////////////////////////////
  // buttons change only after a rising edge, like a debounced source;
  // no bounce is modelled, the design's synchroniser is what is judged
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pins <= 4'h0;
    end else begin
      pins <= press; // active-high control level on each pin
    end
  end
endmodule

// *** testbench/mpfs_top_test.sv ***
`timescale 1ns/100ps
module mpfs_top_test;
  import mpfs_pkg::*;
  logic        clk;
  logic        rst_n;
  logic        wb_cyc;
  logic        wb_stb;
  logic        wb_we;
  logic [9:0]  wb_adr;
  logic [3:0]  wb_sel;
  logic [31:0] wb_wdat;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic [3:0]  press;
  logic [3:0]  pins;
  logic [3:0]  prim;
  logic [10:0] ctl_o;
  logic [3:0]  mute_adc;
  logic [1:0]  mute_dac;
  logic        bank_switch;
  logic        compress_en;
  logic        dsp_bypass;
  logic        vol_up_req;
  logic        vol_down_req;
  int          failures;
  int          check_count;
  // rows: {code[15:11], expected controls[10:0]}
  logic [15:0] rows [17] = '{16'h0880, 16'h1100, 16'h1a00, 16'h2400, 16'h2980, 16'h3600,
    16'h3f80, 16'h4020, 16'h4840, 16'h5060, 16'h5810, 16'h7008, 16'h7804, 16'h8002,
    16'h8801, 16'h9000, 16'hf800};

  //////////////////////////////////////////////////////////////////////
  // clock and bench-wide views
  always #20 clk = ~clk;
  assign ctl_o = {mute_adc, mute_dac, bank_switch, compress_en, dsp_bypass, vol_up_req,
                  vol_down_req};

  mpfs_pin_model pin_u (
    .clk   (clk),
    .rst_n (rst_n),
    .press (press),
    .pins  (pins)
  );

  mpfs_top dut_u (
    .clk                (clk),
    .rst_n              (rst_n),
    .wb_cyc_i           (wb_cyc),
    .wb_stb_i           (wb_stb),
    .wb_we_i            (wb_we),
    .wb_adr_i           (wb_adr),
    .wb_sel_i           (wb_sel),
    .wb_dat_i           (wb_wdat),
    .wb_dat_o           (wb_dat_o),
    .wb_ack_o           (wb_ack_o),
    .bit_clock_pin      (pins[0]),
    .frame_clock_pin    (pins[1]),
    .mic_pair_a_pin     (pins[2]),
    .mic_pair_b_pin     (pins[3]),
    .serial_bit_clock   (prim[0]),
    .serial_frame_clock (prim[1]),
    .mic_pair_a_data    (prim[2]),
    .mic_pair_b_data    (prim[3]),
    .mute_adc           (mute_adc),
    .mute_dac           (mute_dac),
    .bank_switch        (bank_switch),
    .compress_en        (compress_en),
    .dsp_bypass         (dsp_bypass),
    .vol_up_req         (vol_up_req),
    .vol_down_req       (vol_down_req)
  );

  //////////////////////////////////////////////////////////////////////
  // shared tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one classic cycle; a dead slave is left to the watchdog, not a local limit
  task automatic wb_io(input logic we, input logic [7:0] idx, input logic [31:0] d,
                       input logic [3:0] sel, output logic [31:0] rd);
    @(posedge clk);
    wb_cyc  <= 1'b1;
    wb_stb  <= 1'b1;
    wb_we   <= we;
    wb_adr  <= {idx, 2'b00};
    wb_sel  <= sel;
    wb_wdat <= d;
    do begin
      @(posedge clk);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] rd;
    wb_io(1'b0, idx, 32'h0, 4'hf, rd);
    chk(rd, exp);
  endtask

  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
  endtask

  task automatic conclude();
    $display("checks=%0d mismatches=%0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////
  // watchdog: the whole run needs well under 3000 cycles
  initial begin
    #(40 * 20000);
    failures++;
    conclude();
  end

  //////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    logic [31:0] rd;
    int          p;
    clk = 1'b0;
    rst_n = 1'b0;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 10'h000;
    wb_sel = 4'h0;
    wb_wdat = 32'h0;
    press = 4'h0;
    failures = 0;
    check_count = 0;
    do_reset();
    // reset values of all five registers
    rd_chk(8'h3a, 32'h0);
    rd_chk(8'h3b, 32'h0);
    rd_chk(8'h3c, 32'h0);
    rd_chk(8'h3d, 32'h0);
    rd_chk(8'h3e, 32'h11);
    $display("test reset values done");
    // codes held in the table; spare codes 0x0c and 0x0d are never written
    for (int i = 0; i < 17; i++) begin
      p = i % 4;
      wb_io(1'b1, 8'h3a + 8'(p), {27'h0, rows[i][15:11]}, 4'h1, rd);
      press <= 4'(1 << p);
      repeat (6) @(posedge clk);
      chk(ctl_o, rows[i][10:0]);
      chk(prim, 4'h0);
      press <= 4'h0;
      repeat (6) @(posedge clk);
      chk(ctl_o, 11'h0);
      wb_io(1'b1, 8'h3a + 8'(p), 32'h0, 4'h1, rd);
    end
    $display("test code table done");
    // primary role on every pin with code zero
    press <= 4'hf;
    repeat (6) @(posedge clk);
    chk(prim, 4'hf);
    chk(ctl_o, 11'h0);
    press <= 4'h0;
    repeat (6) @(posedge clk);
    chk(prim, 4'h0);
    // two pins asking for different mutes at once combine
    wb_io(1'b1, 8'h3c, 32'h01, 4'h1, rd);
    wb_io(1'b1, 8'h3d, 32'h03, 4'h1, rd);
    press <= 4'hc;
    repeat (6) @(posedge clk);
    chk(ctl_o, 11'h280);
    press <= 4'h0;
    $display("test primary and combine done");
    // spare bits, lane select, upper data bits and an unmapped index
    wb_io(1'b1, 8'h3b, 32'hffffffe0, 4'hf, rd);
    rd_chk(8'h3b, 32'he0);
    wb_io(1'b1, 8'h3a, 32'h0f, 4'h2, rd);
    rd_chk(8'h3a, 32'h0);
    wb_io(1'b1, 8'h3f, 32'h0f, 4'h1, rd);
    rd_chk(8'h3f, 32'h0);
    // mid-run reset restores the sixth pin default
    wb_io(1'b1, 8'h3e, 32'h00, 4'h1, rd);
    rd_chk(8'h3e, 32'h0);
    do_reset();
    rd_chk(8'h3e, 32'h11);
    rd_chk(8'h3b, 32'h0);
    $display("test registers and second reset done");
    conclude();
  end
endmodule
